// >>> hw/gdcl_top.sv
// Gate driver control logic: PWM combining, fault collection, clamp, energy level, APB registers
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module gdcl_top #(
  parameter int FILT_CYC = gdcl_pkg::FLT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gdcl_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // PWM inputs
  input wire logic noninverting_pwm_input,
  input wire logic inverting_pwm_input,
  // Primary monitors
  input wire logic primary_supply_uv,
  input wire logic primary_ot,
  // Secondary monitors, before the isolation link
  input wire logic positive_gate_rail_uv,
  input wire logic positive_gate_rail_ov,
  input wire logic negative_rail_feedback_ov,
  input wire logic secondary_ot,
  input wire logic secondary_rails_settled,
  // Gate below clamp threshold relative to negative_gate_rail
  input wire logic gate_below_clamp,
  // Energy select pin sense
  input wire logic energy_level_select_low,
  input wire logic energy_level_select_high,
  output logic [1:0] energy_level,
  // Output stage
  output logic gate_drive_output,
  output logic gate_pull_up,
  output logic gate_pull_down,
  output logic miller_clamp,
  // Open-drain fault flag
  input wire logic fault_flag_n_i,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe
);

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    gdcl_pkg::gdcl_state_e state;
    logic el_valid;
    logic [1:0] energy;
    logic [gdcl_pkg::LINK_STAGES-1:0][gdcl_pkg::NSEC-1:0] link;
    logic gate;
    logic clamp;
    logic rdy_q;
    logic [gdcl_pkg::NFLT-1:0] flt_q;
    logic ctrl_en;
    logic [gdcl_pkg::NEVT-1:0] irq_stat;
    logic [gdcl_pkg::NEVT-1:0] irq_en;
    logic [7:0] flt_cnt;
    logic [31:0] rdata;
  } gdcl_core_s;

  localparam gdcl_core_s S_RST = '{
    state: gdcl_pkg::ST_STARTUP,
    el_valid: 1'b0,
    energy: gdcl_pkg::EL_MED,
    link: '0,
    gate: 1'b0,
    clamp: 1'b0,
    rdy_q: 1'b0,
    flt_q: '0,
    ctrl_en: gdcl_pkg::CTRL_EN_RST,
    irq_stat: '0,
    irq_en: gdcl_pkg::IRQ_EN_RST,
    flt_cnt: 8'h00,
    rdata: 32'h0000_0000
  };

  gdcl_core_s s_r;
  gdcl_core_s s_nxt;

  // ***************************************************
  // Secondary fault filter
  // ***************************************************
  gdcl_flt_if #(.N(gdcl_pkg::NSEC)) sec_if ();

  // Only the far end of the link pipeline feeds the filter
  assign sec_if.raw = s_r.link[gdcl_pkg::LINK_STAGES-1];

  gdcl_fault_filter #(
    .N(gdcl_pkg::NSEC),
    .FCYC(FILT_CYC)
  ) u_sec_filter (
    .pclk(pclk),
    .presetn(presetn),
    .flt(sec_if.filt_side)
  );

  // ***************************************************
  // Combinational helpers
  // ***************************************************
  logic [gdcl_pkg::NFLT-1:0] flt_v;
  logic any_fault;
  logic cmd;
  logic gate_ok;
  logic ready;
  logic [gdcl_pkg::NEVT-1:0] ev;
  logic [gdcl_pkg::NEVT-1:0] clr;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic [1:0] el_dec;
  logic [31:0] rd_val;

  // ***************************************************
  // APB decode
  // ***************************************************
  always_comb begin
    mapped = 1'b0;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      gdcl_pkg::ADDR_CTRL: begin
        mapped = 1'b1;
        rd_val = {31'h0000_0000, s_r.ctrl_en};
      end
      gdcl_pkg::ADDR_STATUS: begin
        mapped = 1'b1;
        rd_val = {20'h0_0000, s_r.gate, s_r.clamp, s_r.energy, fault_flag_n_i,
                  s_r.state == gdcl_pkg::ST_RUN, flt_v};
      end
      gdcl_pkg::ADDR_IRQ_STAT: begin
        mapped = 1'b1;
        rd_val = {24'h00_0000, s_r.irq_stat};
      end
      gdcl_pkg::ADDR_IRQ_CLR: begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
      end
      gdcl_pkg::ADDR_IRQ_EN: begin
        mapped = 1'b1;
        rd_val = {24'h00_0000, s_r.irq_en};
      end
      gdcl_pkg::ADDR_FLT_CNT: begin
        mapped = 1'b1;
        rd_val = {24'h00_0000, s_r.flt_cnt};
      end
      default: begin
        mapped = 1'b0;
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // ***************************************************
  // Next-state logic
  // ***************************************************
  always_comb begin
    s_nxt = s_r;
    wr_acc = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;

    // Fault collection, primary direct, secondary filtered
    flt_v = '0;
    flt_v[gdcl_pkg::FLT_PRI_UV] = primary_supply_uv;
    flt_v[gdcl_pkg::FLT_PRI_OT] = primary_ot;
    flt_v[gdcl_pkg::FLT_SEC_OT:gdcl_pkg::FLT_POS_UV] = sec_if.filt;
    any_fault = |flt_v;

    // Isolation link transfer
    s_nxt.link[0] = {secondary_ot, negative_rail_feedback_ov, positive_gate_rail_ov, positive_gate_rail_uv};
    for (int i = 1; i < gdcl_pkg::LINK_STAGES; i++) begin
      s_nxt.link[i] = s_r.link[i-1];
    end

    // Energy level, decoded once after power-up
    if (energy_level_select_low && !energy_level_select_high) begin
      el_dec = gdcl_pkg::EL_LOW;
    end else if (energy_level_select_high && !energy_level_select_low) begin
      el_dec = gdcl_pkg::EL_HIGH;
    end else begin
      el_dec = gdcl_pkg::EL_MED;
    end
    if (!s_r.el_valid) begin
      s_nxt.energy = el_dec;
      s_nxt.el_valid = 1'b1;
    end

    // Readiness sequence
    unique case (s_r.state)
      gdcl_pkg::ST_STARTUP: begin
        if (s_r.el_valid && secondary_rails_settled && !any_fault && s_r.ctrl_en) begin
          s_nxt.state = gdcl_pkg::ST_RUN;
        end
      end
      gdcl_pkg::ST_RUN: begin
        if (any_fault || !secondary_rails_settled || !s_r.ctrl_en) begin
          s_nxt.state = gdcl_pkg::ST_FAULT;
        end
      end
      gdcl_pkg::ST_FAULT: begin
        // No latch: recovery needs no software action
        if (!any_fault && secondary_rails_settled && s_r.ctrl_en) begin
          s_nxt.state = gdcl_pkg::ST_RUN;
        end
      end
      // Unused code: fall back to the held-off startup state
      default: begin
        s_nxt.state = gdcl_pkg::ST_STARTUP;
      end
    endcase
    ready = (s_r.state == gdcl_pkg::ST_RUN);

    // Gate command
    cmd = noninverting_pwm_input && !inverting_pwm_input;
    // Next state used so a new fault kills the pull-up in the same edge
    gate_ok = (s_nxt.state == gdcl_pkg::ST_RUN) && !any_fault;
    s_nxt.gate = cmd && gate_ok;
    if (flt_v[gdcl_pkg::FLT_PRI_OT] || flt_v[gdcl_pkg::FLT_SEC_OT]) begin
      s_nxt.gate = 1'b0;
    end

    // Miller clamp
    if (s_nxt.gate && !s_r.gate) begin
      s_nxt.clamp = 1'b0;
    end else if (!s_r.gate && gate_below_clamp) begin
      s_nxt.clamp = 1'b1;
    end

    // Events
    ev = '0;
    ev[gdcl_pkg::NFLT-1:0] = flt_v & ~s_r.flt_q;
    ev[gdcl_pkg::EVT_READY] = ready && !s_r.rdy_q;
    ev[gdcl_pkg::EVT_LOST] = !ready && s_r.rdy_q;
    s_nxt.flt_q = flt_v;
    s_nxt.rdy_q = ready;
    if (s_r.state == gdcl_pkg::ST_RUN && s_nxt.state == gdcl_pkg::ST_FAULT &&
        s_r.flt_cnt != gdcl_pkg::FLT_CNT_MAX) begin
      s_nxt.flt_cnt = s_r.flt_cnt + 8'h01;
    end

    // Register writes
    clr = '0;
    if (wr_acc) begin
      unique case (paddr)
        gdcl_pkg::ADDR_CTRL: s_nxt.ctrl_en = pwdata[0];
        gdcl_pkg::ADDR_IRQ_CLR: clr = pwdata[gdcl_pkg::NEVT-1:0];
        gdcl_pkg::ADDR_IRQ_EN: s_nxt.irq_en = pwdata[gdcl_pkg::NEVT-1:0];
        gdcl_pkg::ADDR_FLT_CNT: s_nxt.flt_cnt = 8'h00;
        default: begin
        end
      endcase
    end
    // Set beats clear so a coincident event is kept
    s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;

    // Read data captured in the setup cycle
    if (rd_setup) begin
      s_nxt.rdata = rd_val;
    end
  end

  // ***************************************************
  // State register
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq = |(s_r.irq_stat & s_r.irq_en);
  assign energy_level = s_r.energy;
  assign gate_drive_output = s_r.gate;
  assign gate_pull_up = s_r.gate;
  // Reset value of the gate flop keeps the pull-down on from power-up
  assign gate_pull_down = !s_r.gate;
  assign miller_clamp = s_r.clamp;
  assign fault_flag_n_o = 1'b0;
  assign fault_flag_n_oe = (s_r.state != gdcl_pkg::ST_RUN);

endmodule : gdcl_top

// >>> hw/gdcl_pkg.sv
// Shared constants, register map and types of the gate driver control logic
package gdcl_pkg;

  // ***************************************************
  // Clock and timing
  // ***************************************************
  localparam int CLK_FREQ_MHZ = 125;
  localparam int FLT_TIME_NS = 64;
  localparam int FLT_CYC = (FLT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int LINK_STAGES = 2;

  // ***************************************************
  // Fault vector layout
  // ***************************************************
  localparam int NFLT = 6;
  localparam int NSEC = 4;
  localparam int FLT_PRI_UV = 0;
  localparam int FLT_PRI_OT = 1;
  localparam int FLT_POS_UV = 2;
  localparam int FLT_POS_OV = 3;
  localparam int FLT_NFB_OV = 4;
  localparam int FLT_SEC_OT = 5;
  localparam int NEVT = 8;
  localparam int EVT_READY = 6;
  localparam int EVT_LOST = 7;

  // ***************************************************
  // Register map, byte addresses
  // ***************************************************
  localparam int PADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADDR_FLT_CNT = 8'h14;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic [NEVT-1:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] FLT_CNT_MAX = 8'hFF;

  // ***************************************************
  // Energy level codes
  // ***************************************************
  localparam logic [1:0] EL_LOW = 2'h0;
  localparam logic [1:0] EL_MED = 2'h1;
  localparam logic [1:0] EL_HIGH = 2'h2;

  typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_FAULT} gdcl_state_e;

endpackage : gdcl_pkg

// >>> hw/gdcl_flt_if.sv
// Carrier between the control core and the secondary fault filter
`timescale 1ns/1ps
interface gdcl_flt_if #(
  parameter int N = 4
);
  logic [N-1:0] raw;
  logic [N-1:0] filt;
  modport filt_side (input raw, output filt);
  modport user (output raw, input filt);
endinterface : gdcl_flt_if

// >>> hw/gdcl_fault_filter.sv
// Short-duration filter on faults arriving over the isolation link
`timescale 1ns/1ps
module gdcl_fault_filter #(
  parameter int N = 4,
  parameter int FCYC = gdcl_pkg::FLT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  gdcl_flt_if.filt_side flt
);
  localparam int CW = $clog2(FCYC + 1);

  typedef struct packed {
    logic [N-1:0][CW-1:0] cnt;
    logic [N-1:0] filt;
  } gdcl_filt_s;

  gdcl_filt_s s_r;
  gdcl_filt_s s_nxt;

  // ***************************************************
  // Per-bit stability counter
  // ***************************************************
  // A change passes only after FCYC cycles of the same new value
  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < N; i++) begin
      if (flt.raw[i] == s_r.filt[i]) begin
        s_nxt.cnt[i] = '0;
      end else if (s_r.cnt[i] == CW'(FCYC - 1)) begin
        s_nxt.cnt[i] = '0;
        s_nxt.filt[i] = flt.raw[i];
      end else begin
        s_nxt.cnt[i] = s_r.cnt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flt.filt = s_r.filt;

endmodule : gdcl_fault_filter

// >>> dv/gdcl_assertions.sv
// Port assertions for the gate driver control logic
`timescale 1ns/1ps
module gdcl_checker #(
  parameter int FILT_CYC = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic noninverting_pwm_input,
  input wire logic inverting_pwm_input,
  input wire logic primary_supply_uv,
  input wire logic primary_ot,
  input wire logic secondary_ot,
  input wire logic gate_below_clamp,
  input wire logic [1:0] energy_level,
  input wire logic gate_drive_output,
  input wire logic gate_pull_up,
  input wire logic gate_pull_down,
  input wire logic miller_clamp,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe
);
  // ************************
  // Helpers
  // ************************
  // Link stages, filter length, then one edge for the state flop
  localparam int SOT_LIM = gdcl_pkg::LINK_STAGES + FILT_CYC + 1;
  logic [7:0] sot_run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sot_run <= 8'h00;
    end else if (!secondary_ot) begin
      sot_run <= 8'h00;
    end else if (sot_run != 8'hFF) begin
      sot_run <= sot_run + 8'h01;
    end
  end

  // ************************
  // Properties
  // ************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_gate_truth: assert property (gate_drive_output |-> $past(noninverting_pwm_input && !inverting_pwm_input))
    else $error("gate high without on command");
  a_pull_pair: assert property (gate_pull_up == gate_drive_output && gate_pull_down == !gate_drive_output)
    else $error("pull pair disagrees with command");
  a_ot_kill: assert property (primary_ot |=> !gate_pull_up && gate_pull_down)
    else $error("pull-up alive in overtemperature");
  a_fault_flag: assert property (primary_supply_uv || primary_ot |=> fault_flag_n_oe)
    else $error("primary fault not flagged");
  a_open_drain: assert property (fault_flag_n_o == 1'b0)
    else $error("flag drives high");
  a_pwm_ignored: assert property (fault_flag_n_oe |-> !gate_drive_output)
    else $error("gate on while not ready");
  a_clamp_set: assert property ((gate_below_clamp && !gate_drive_output) ##1 !gate_drive_output |-> miller_clamp)
    else $error("clamp did not engage");
  a_clamp_free: assert property ($rose(gate_drive_output) |-> !miller_clamp)
    else $error("clamp held over rising command");
  a_clamp_hold: assert property ($fell(miller_clamp) |-> $rose(gate_drive_output))
    else $error("clamp dropped without rising command");
  a_energy_hold: assert property (!$stable(energy_level) |-> !$past(presetn, 2))
    else $error("energy level moved after startup");
  a_sec_flag: assert property (sot_run >= 8'(SOT_LIM) |-> fault_flag_n_oe)
    else $error("secondary overtemperature not flagged");
  c_gate_on: cover property ($rose(gate_drive_output));
  c_clamp_on: cover property ($rose(miller_clamp));
  c_flag_low: cover property ($rose(fault_flag_n_oe));
endmodule : gdcl_checker

bind gdcl_top gdcl_checker #(.FILT_CYC(FILT_CYC)) chk_u (.pclk, .presetn, .noninverting_pwm_input,
  .inverting_pwm_input, .primary_supply_uv, .primary_ot, .gate_below_clamp, .energy_level, .gate_drive_output,
  .gate_pull_up, .gate_pull_down, .miller_clamp, .fault_flag_n_o, .fault_flag_n_oe, .secondary_ot);

// >>> dv/gdcl_ctrl_model.sv
// System controller model: drives the PWM pair, resolves the shared fault line
`timescale 1ns/1ps
module gdcl_ctrl_model (
  input wire logic pclk,
  input wire logic [1:0] mode,
  input wire logic cmd,
  input wire logic [1:0] raw,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe,
  output logic nin,
  output logic inv,
  output logic fault_line
);
  // Unused input parked at the level that lets the other one pass (inv low, nin high), never left to the pulls
  always @(posedge pclk) begin
    case (mode)
      2'h0: {nin, inv} <= {cmd, 1'b0};
      2'h1: {nin, inv} <= {1'b1, !cmd};
      default: {nin, inv} <= raw;
    endcase
  end
  // External pull-up; line only low while the flag sinks
  assign fault_line = (fault_flag_n_oe && !fault_flag_n_o) ? 1'b0 : 1'b1;
endmodule : gdcl_ctrl_model

// >>> dv/tb_gate_driver_control_logic.sv
// Self-checking testbench of the gate driver control logic
`timescale 1ns/1ps
module tb_gate_driver_control_logic;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, err, e, cmd = 1'b0;
  logic noninverting_pwm_input, inverting_pwm_input, secondary_rails_settled = 1'b0, gate_below_clamp = 1'b0;
  logic primary_supply_uv, primary_ot, positive_gate_rail_uv, positive_gate_rail_ov, negative_rail_feedback_ov;
  logic secondary_ot, energy_level_select_low = 1'b0, energy_level_select_high = 1'b0;
  logic gate_drive_output, gate_pull_up, gate_pull_down, miller_clamp;
  logic fault_flag_n_i, fault_flag_n_o, fault_flag_n_oe;
  logic [1:0] energy_level, mode = 2'h2, raw = 2'h0;
  logic [5:0] flt = 6'h00;
  int mismatches = 0, num_checks = 0, cyc = 0, seed = 84, n, i;

  assign {secondary_ot, negative_rail_feedback_ov, positive_gate_rail_ov} = flt[5:3];
  assign {positive_gate_rail_uv, primary_ot, primary_supply_uv} = flt[2:0];
  always #4 pclk = ~pclk;

  // Short filter keeps fault tests brief
  gdcl_top #(.FILT_CYC(2)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .noninverting_pwm_input, .inverting_pwm_input, .primary_supply_uv, .primary_ot,
    .positive_gate_rail_uv, .positive_gate_rail_ov, .negative_rail_feedback_ov, .secondary_ot,
    .secondary_rails_settled, .gate_below_clamp, .energy_level_select_low, .energy_level_select_high,
    .energy_level, .gate_drive_output, .gate_pull_up, .gate_pull_down, .miller_clamp, .fault_flag_n_i,
    .fault_flag_n_o, .fault_flag_n_oe);
  gdcl_ctrl_model ctl_u (.pclk, .mode, .cmd, .raw, .fault_flag_n_o, .fault_flag_n_oe,
    .nin(noninverting_pwm_input), .inv(inverting_pwm_input), .fault_line(fault_flag_n_i));

  // ************************
  // Tasks
  // ************************
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_oe(input logic v);
    n = 0;
    while (fault_flag_n_oe !== v && n < 200) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("oe", 32'(v), 32'(fault_flag_n_oe));
  endtask : wait_oe

  task automatic do_reset(input logic [1:0] sense, input logic [1:0] ex);
    @(posedge pclk);
    presetn <= 1'b0;
    {energy_level_select_low, energy_level_select_high} <= sense;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    {energy_level_select_low, energy_level_select_high} <= ~sense;
    repeat (3) @(posedge pclk);
    #1;
    chk("energy", 32'(ex), 32'(energy_level));
  endtask : do_reset

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // A hang counts against the run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ************************
  // Sequence
  // ************************
  initial begin
    do_reset(2'h2, gdcl_pkg::EL_LOW);
    do_reset(2'h1, gdcl_pkg::EL_HIGH);
    do_reset(2'h0, gdcl_pkg::EL_MED);
    chk("flag startup", 32'h2, 32'({fault_flag_n_oe, fault_flag_n_i}));
    @(posedge pclk);
    secondary_rails_settled <= 1'b1;
    wait_oe(1'b0);
    chk("line ready", 32'h1, 32'(fault_flag_n_i));
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, 32'(err));
    chk("pready", 32'h1, 32'(pready));
    apb(1'b1, gdcl_pkg::ADDR_IRQ_EN, 32'h2);
    for (i = 0; i < 80; i++) begin
      @(posedge pclk);
      // Ready throughout: rails settled, no fault, drive enabled
      e = noninverting_pwm_input & !inverting_pwm_input;
      mode <= (i < 4) ? 2'h2 : 2'({$random(seed)} % 3);
      raw <= (i < 4) ? 2'(i) : 2'($random(seed));
      cmd <= 1'($random(seed));
      #1;
      chk("gate", 32'({e, e, !e}), 32'({gate_drive_output, gate_pull_up, gate_pull_down}));
    end
    @(posedge pclk);
    mode <= 2'h2;
    raw <= 2'h2;
    repeat (4) @(posedge pclk);
    raw <= 2'h0;
    gate_below_clamp <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    chk("clamp set", 32'h1, 32'({gate_drive_output, miller_clamp}));
    @(posedge pclk);
    raw <= 2'h2;
    repeat (4) @(posedge pclk);
    #1;
    chk("clamp free", 32'h2, 32'({gate_drive_output, miller_clamp}));
    for (i = 0; i < 6; i++) begin
      @(posedge pclk);
      flt <= 6'(1 << i);
      gate_below_clamp <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
      chk("early flag", 32'(i < 2), 32'(fault_flag_n_oe));
      wait_oe(1'b1);
      chk("gate off", 32'h1, 32'({gate_drive_output, gate_pull_up, gate_pull_down}));
      apb(1'b0, gdcl_pkg::ADDR_STATUS, 32'h0);
      chk("status", 1 << i, rd & 32'h7F);
      apb(1'b0, gdcl_pkg::ADDR_IRQ_STAT, 32'h0);
      chk("irq", 32'({1'b1, i == gdcl_pkg::FLT_PRI_OT}), 32'({rd[i], irq}));
      @(posedge pclk);
      flt <= 6'h00;
      wait_oe(1'b0);
      apb(1'b1, gdcl_pkg::ADDR_IRQ_CLR, 32'hFF);
      apb(1'b0, gdcl_pkg::ADDR_IRQ_STAT, 32'h0);
      chk("irq clear", 32'h0, 32'({rd[7:0], irq}));
    end
    // Drive disable: six fault entries so far, this one makes seven
    apb(1'b1, gdcl_pkg::ADDR_CTRL, 32'h0);
    wait_oe(1'b1);
    chk("gate disabled", 32'h1, 32'({gate_drive_output, gate_pull_up, gate_pull_down}));
    apb(1'b0, gdcl_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, gdcl_pkg::ADDR_FLT_CNT, 32'h0);
    chk("fault count", 32'h7, rd);
    apb(1'b1, gdcl_pkg::ADDR_FLT_CNT, 32'h0);
    apb(1'b0, gdcl_pkg::ADDR_FLT_CNT, 32'h0);
    chk("count clear", 32'h0, rd);
    apb(1'b1, gdcl_pkg::ADDR_CTRL, 32'h1);
    wait_oe(1'b0);
    do_reset(2'h2, gdcl_pkg::EL_LOW);
    print_verdict();
  end
endmodule : tb_gate_driver_control_logic
